/* File: bench/azt_zone_select_properties.sv */
// Checker of the zone selector port behaviour.
`timescale 1ns/1ps
module azt_zone_select_properties (
  input wire logic       ref_clk_in,
  input wire logic       resetn_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [7:0] ambient_light_input_in,
  input wire logic       linear_curve_in,
  input wire logic [2:0] zone_out,
  input wire logic       zone_change_out,
  input wire logic [6:0] brightness_code_out,
  input wire logic       linear_curve_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  property p_chg_set; $changed(zone_out) |-> zone_change_out; endproperty
  a_chg_set: assert property (p_chg_set) else $error("flag missed");
  property p_chg_only; zone_change_out |-> $changed(zone_out); endproperty
  a_chg_only: assert property (p_chg_only) else $error("stray flag");
  property p_curve;
    $past(resetn_in) |-> linear_curve_out == $past(linear_curve_in);
  endproperty
  a_curve: assert property (p_curve) else $error("curve bad");
  property p_unmap;
    reg_rd_in && reg_addr_in == 8'h50 |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_bit7;
    reg_rd_in && reg_addr_in[7:4] == 4'h7 |=> !reg_rdata_out[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("target bit7 set");
  property p_top;
    ambient_light_input_in == 8'hFF |=> zone_out == 3'h4;
  endproperty
  a_top: assert property (p_top) else $error("full scale zone");
  property p_brt;
    !reg_wr_in ##2 $stable(zone_out) |-> $stable(brightness_code_out);
  endproperty
  a_brt: assert property (p_brt) else $error("brightness moved");
endmodule : azt_zone_select_properties

bind azt_zone_select azt_zone_select_properties i_props (.*);

/* File: bench/azt_zone_select_tb.sv */
// Self-checking bench of the zone selector.
`timescale 1ns/1ps
module azt_zone_select_tb;
  logic        ref_clk_in = 0, resetn_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic        linear_curve_in = 0, zone_change_out, linear_curve_out;
  logic [7:0]  reg_addr_in = 0, reg_wdata_in = 0, amb = 0, reg_rdata_out;
  logic [2:0]  zone_out, pz;
  logic [6:0]  brightness_code_out;
  int          n_mismatch = 0, check_count = 0;
  logic [23:0] rows [10] = '{24'h00_0019, 24'h32_0019, 24'h33_0133,
    24'h65_0133, 24'h66_024C, 24'h99_0366, 24'hCB_0366, 24'hCC_047F,
    24'hFF_047F, 24'h10_0019};
  logic [15:0] regs [10] = '{16'h6033, 16'h6166, 16'h6299, 16'h63CC,
    16'h7019, 16'h7133, 16'h724C, 16'h7366, 16'h747F, 16'h5000};
  always #2.5 ref_clk_in = ~ref_clk_in;
  azt_zone_select i_dut (.ref_clk_in, .resetn_in, .reg_wr_in, .reg_rd_in,
    .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .linear_curve_in,
    .ambient_light_input_in(amb), .zone_out, .zone_change_out,
    .brightness_code_out, .linear_curve_out);
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1;
    @(negedge ref_clk_in);
    reg_wr_in = 0;
    @(negedge ref_clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_in = a;
    reg_rd_in = 1;
    @(negedge ref_clk_in);
    reg_rd_in = 0;
    @(negedge ref_clk_in);
    chk(reg_rdata_out, e);
  endtask : rd
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  // ==========================================================================
  // Tests
  initial begin
    #5000;
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (5) @(negedge ref_clk_in);
    resetn_in = 1;
    pz = 3'h0;
    foreach (rows[i]) begin
      amb = rows[i][23:16];
      @(negedge ref_clk_in);
      chk(zone_out, rows[i][10:8]);
      chk(brightness_code_out, rows[i][6:0]);
      chk(zone_change_out, rows[i][10:8] != pz);
      pz = rows[i][10:8];
    end
    $display("zone table done");
    foreach (regs[i]) rd(regs[i][15:8], regs[i][7:0]);
    $display("reset values done");
    amb = 8'hFF;
    wr(8'h74, 8'h85);
    @(negedge ref_clk_in);
    chk(brightness_code_out, 8'h05);
    rd(8'h74, 8'h05);
    wr(8'h60, 8'h40);
    amb = 8'h3F;
    @(negedge ref_clk_in);
    chk(zone_out, 8'h00);
    amb = 8'h40;
    linear_curve_in = 1;
    @(negedge ref_clk_in);
    chk(zone_out, 8'h01);
    chk(linear_curve_out, 8'h01);
    $display("write tests done");
    resetn_in = 0;
    @(negedge ref_clk_in);
    chk(brightness_code_out, 8'h19);
    chk(zone_out, 8'h00);
    chk(zone_change_out, 8'h00);
    chk(linear_curve_out, 8'h00);
    chk(reg_rdata_out, 8'h00);
    resetn_in = 1;
    rd(8'h60, 8'h33);
    chk(zone_out, 8'h01);
    chk(linear_curve_out, 8'h01);
    $display("second reset done");
    test_done();
  end
endmodule : azt_zone_select_tb

/* File: core/azt_pkg.sv */
// Package with register map, reset values and zone codes of the zone selector.
package azt_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] AZT_ADDR_THRESHOLD_0  = 8'h60;
  localparam logic [7:0] AZT_ADDR_THRESHOLD_1  = 8'h61;
  localparam logic [7:0] AZT_ADDR_THRESHOLD_2  = 8'h62;
  localparam logic [7:0] AZT_ADDR_THRESHOLD_3  = 8'h63;
  localparam logic [7:0] AZT_ADDR_BRIGHTNESS_0 = 8'h70;
  localparam logic [7:0] AZT_ADDR_BRIGHTNESS_1 = 8'h71;
  localparam logic [7:0] AZT_ADDR_BRIGHTNESS_2 = 8'h72;
  localparam logic [7:0] AZT_ADDR_BRIGHTNESS_3 = 8'h73;
  localparam logic [7:0] AZT_ADDR_BRIGHTNESS_4 = 8'h74;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] AZT_RST_THRESHOLD_0  = 8'h33;
  localparam logic [7:0] AZT_RST_THRESHOLD_1  = 8'h66;
  localparam logic [7:0] AZT_RST_THRESHOLD_2  = 8'h99;
  localparam logic [7:0] AZT_RST_THRESHOLD_3  = 8'hCC;
  localparam logic [6:0] AZT_RST_BRIGHTNESS_0 = 7'h19;
  localparam logic [6:0] AZT_RST_BRIGHTNESS_1 = 7'h33;
  localparam logic [6:0] AZT_RST_BRIGHTNESS_2 = 7'h4C;
  localparam logic [6:0] AZT_RST_BRIGHTNESS_3 = 7'h66;
  localparam logic [6:0] AZT_RST_BRIGHTNESS_4 = 7'h7F;
  localparam logic [7:0] AZT_READ_UNMAPPED    = 8'h00;
  localparam int         AZT_CODE_MSB         = 6;

  // ==========================================================================
  // Zone codes
  typedef enum logic [2:0] {
    AZT_ZONE_0 = 3'h0,
    AZT_ZONE_1 = 3'h1,
    AZT_ZONE_2 = 3'h2,
    AZT_ZONE_3 = 3'h3,
    AZT_ZONE_4 = 3'h4
  } azt_zone_e;

endpackage : azt_pkg

/* File: core/azt_zone_select.sv */
// Zone thresholds, zone targets and active-zone brightness selection.
//
// Operation
// - Four 8-bit thresholds split 1V input range.
// - Thresholds reset to 20/40/60/80 percent scale.
// - Lower thresholds reset 0x33/0x66/0x99 at 0x60-0x62.
// - Five targets; active zone's target drives brightness.
// - Targets are 7-bit codes with documented resets.
// - Below first threshold selects zone zero.
// - Between thresholds selects zones one to three.
// - Above fourth threshold selects zone four.
// - Report 3-bit zone; flag every zone change.
// - Curve select: 0 exponential, 1 linear.
`timescale 1ns/1ps

module azt_zone_select
  import azt_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic [7:0] ambient_light_input_in,
  input  wire logic       linear_curve_in,
  output logic      [2:0] zone_out,
  output logic            zone_change_out,
  output logic      [6:0] brightness_code_out,
  output logic            linear_curve_out
);

  // ==========================================================================
  // Register storage
  logic [7:0] zone_threshold_0;
  logic [7:0] zone_threshold_1;
  logic [7:0] zone_threshold_2;
  logic [7:0] zone_threshold_3;
  logic [6:0] zone_brightness_0;
  logic [6:0] zone_brightness_1;
  logic [6:0] zone_brightness_2;
  logic [6:0] zone_brightness_3;
  logic [6:0] zone_brightness_4;

  wire wr_thr_0 = reg_wr_in && (reg_addr_in == AZT_ADDR_THRESHOLD_0);
  wire wr_thr_1 = reg_wr_in && (reg_addr_in == AZT_ADDR_THRESHOLD_1);
  wire wr_thr_2 = reg_wr_in && (reg_addr_in == AZT_ADDR_THRESHOLD_2);
  wire wr_thr_3 = reg_wr_in && (reg_addr_in == AZT_ADDR_THRESHOLD_3);
  wire wr_brt_0 = reg_wr_in && (reg_addr_in == AZT_ADDR_BRIGHTNESS_0);
  wire wr_brt_1 = reg_wr_in && (reg_addr_in == AZT_ADDR_BRIGHTNESS_1);
  wire wr_brt_2 = reg_wr_in && (reg_addr_in == AZT_ADDR_BRIGHTNESS_2);
  wire wr_brt_3 = reg_wr_in && (reg_addr_in == AZT_ADDR_BRIGHTNESS_3);
  wire wr_brt_4 = reg_wr_in && (reg_addr_in == AZT_ADDR_BRIGHTNESS_4);

  // ==========================================================================
  // Threshold registers
  // Thresholds hold the full 8-bit code; no ordering is enforced here.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      zone_threshold_0 <= AZT_RST_THRESHOLD_0;
    else if (wr_thr_0)
      zone_threshold_0 <= reg_wdata_in;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      zone_threshold_1 <= AZT_RST_THRESHOLD_1;
    else if (wr_thr_1)
      zone_threshold_1 <= reg_wdata_in;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      zone_threshold_2 <= AZT_RST_THRESHOLD_2;
    else if (wr_thr_2)
      zone_threshold_2 <= reg_wdata_in;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      zone_threshold_3 <= AZT_RST_THRESHOLD_3;
    else if (wr_thr_3)
      zone_threshold_3 <= reg_wdata_in;
  end

  // ==========================================================================
  // Target registers
  // Targets keep only the code field; bit 7 of a write is dropped.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      zone_brightness_0 <= AZT_RST_BRIGHTNESS_0;
    else if (wr_brt_0)
      zone_brightness_0 <= reg_wdata_in[AZT_CODE_MSB:0];
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      zone_brightness_1 <= AZT_RST_BRIGHTNESS_1;
    else if (wr_brt_1)
      zone_brightness_1 <= reg_wdata_in[AZT_CODE_MSB:0];
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      zone_brightness_2 <= AZT_RST_BRIGHTNESS_2;
    else if (wr_brt_2)
      zone_brightness_2 <= reg_wdata_in[AZT_CODE_MSB:0];
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      zone_brightness_3 <= AZT_RST_BRIGHTNESS_3;
    else if (wr_brt_3)
      zone_brightness_3 <= reg_wdata_in[AZT_CODE_MSB:0];
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      zone_brightness_4 <= AZT_RST_BRIGHTNESS_4;
    else if (wr_brt_4)
      zone_brightness_4 <= reg_wdata_in[AZT_CODE_MSB:0];
  end

  // ==========================================================================
  // Read path
  logic [7:0] read_mux;

  always_comb begin
    if (reg_addr_in == AZT_ADDR_THRESHOLD_0)
      read_mux = zone_threshold_0;
    else if (reg_addr_in == AZT_ADDR_THRESHOLD_1)
      read_mux = zone_threshold_1;
    else if (reg_addr_in == AZT_ADDR_THRESHOLD_2)
      read_mux = zone_threshold_2;
    else if (reg_addr_in == AZT_ADDR_THRESHOLD_3)
      read_mux = zone_threshold_3;
    else if (reg_addr_in == AZT_ADDR_BRIGHTNESS_0)
      read_mux = {1'b0, zone_brightness_0};
    else if (reg_addr_in == AZT_ADDR_BRIGHTNESS_1)
      read_mux = {1'b0, zone_brightness_1};
    else if (reg_addr_in == AZT_ADDR_BRIGHTNESS_2)
      read_mux = {1'b0, zone_brightness_2};
    else if (reg_addr_in == AZT_ADDR_BRIGHTNESS_3)
      read_mux = {1'b0, zone_brightness_3};
    else if (reg_addr_in == AZT_ADDR_BRIGHTNESS_4)
      read_mux = {1'b0, zone_brightness_4};
    else
      read_mux = AZT_READ_UNMAPPED;
  end

  // Read data is captured on a read strobe and holds until the next one.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      reg_rdata_out <= AZT_READ_UNMAPPED;
    else if (reg_rd_in)
      reg_rdata_out <= read_mux;
  end

  // ==========================================================================
  // Zone classification
  // An input equal to a threshold counts as above it, so ties go upward.
  wire at_or_above_0 = ambient_light_input_in >= zone_threshold_0;
  wire at_or_above_1 = ambient_light_input_in >= zone_threshold_1;
  wire at_or_above_2 = ambient_light_input_in >= zone_threshold_2;
  wire at_or_above_3 = ambient_light_input_in >= zone_threshold_3;

  // Highest crossed threshold wins; with ascending thresholds this is exact.
  azt_zone_e next_zone;
  assign next_zone = at_or_above_3 ? AZT_ZONE_4 :
                     at_or_above_2 ? AZT_ZONE_3 :
                     at_or_above_1 ? AZT_ZONE_2 :
                     at_or_above_0 ? AZT_ZONE_1 :
                                     AZT_ZONE_0;

  logic [6:0] next_brightness_code;

  always_comb begin
    case (next_zone)
      AZT_ZONE_0: next_brightness_code = zone_brightness_0;
      AZT_ZONE_1: next_brightness_code = zone_brightness_1;
      AZT_ZONE_2: next_brightness_code = zone_brightness_2;
      AZT_ZONE_3: next_brightness_code = zone_brightness_3;
      default:    next_brightness_code = zone_brightness_4;
    endcase
  end

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      zone_out <= AZT_ZONE_0;
    else
      zone_out <= next_zone;
  end

  // The flag compares the new zone with the one shown now, so it is high
  // for one cycle, the first cycle in which zone_out shows a new zone.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      zone_change_out <= 1'b0;
    else
      zone_change_out <= (next_zone != azt_zone_e'(zone_out));
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      brightness_code_out <= AZT_RST_BRIGHTNESS_0;
    else
      brightness_code_out <= next_brightness_code;
  end

  // The curve select is only retimed here; the current mapper applies it.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      linear_curve_out <= 1'b0;
    else
      linear_curve_out <= linear_curve_in;
  end

endmodule : azt_zone_select
